// file: src/sar_adc_pkg.sv
// Shared constants for the successive-approximation converter sequencer.
// Assumes a single peripheral clock; one state equals one clock cycle.
package sar_adc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets on the 32-bit slave port (one word each)
    localparam logic [5:0] OFS_RESULT_A_HI   = 6'h00;
    localparam logic [5:0] OFS_RESULT_A_LO   = 6'h04;
    localparam logic [5:0] OFS_RESULT_B_HI   = 6'h08;
    localparam logic [5:0] OFS_RESULT_B_LO   = 6'h0c;
    localparam logic [5:0] OFS_RESULT_C_HI   = 6'h10;
    localparam logic [5:0] OFS_RESULT_C_LO   = 6'h14;
    localparam logic [5:0] OFS_RESULT_D_HI   = 6'h18;
    localparam logic [5:0] OFS_RESULT_D_LO   = 6'h1c;
    localparam logic [5:0] OFS_CTRL_STATUS   = 6'h20;
    localparam logic [5:0] OFS_CTRL          = 6'h24;

    ////////////////////////////////////////////////////////////////////////
    // Field positions in ctrl_status_reg
    localparam int BIT_DONE_FLAG   = 7;
    localparam int BIT_IRQ_ENABLE  = 6;
    localparam int BIT_CONV_START  = 5;
    localparam int BIT_MULTI       = 4;
    localparam int BIT_TIME_SELECT = 3;
    localparam int BIT_GROUP       = 2;
    // Field positions in ctrl_reg
    localparam int BIT_TRIG_EN_HI  = 7;
    localparam int BIT_TRIG_EN_LO  = 6;
    localparam int BIT_SCAN        = 5;

    // Values after reset and standby
    localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET        = 8'h07;
    localparam logic [2:0] CTRL_LOW_ONES     = 3'h7;

    ////////////////////////////////////////////////////////////////////////
    // Timing, in states, and the derived cycle counts
    localparam int CYCLES_PER_STATE    = 1;
    localparam int DELAY_MIN_SLOW      = 17;
    localparam int DELAY_MIN_FAST      = 10;
    localparam int SAMPLE_SLOW_STATES  = 129;
    localparam int SAMPLE_FAST_STATES  = 65;
    localparam int TOTAL_MIN_SLOW      = 514;
    localparam int TOTAL_MIN_FAST      = 259;
    localparam int NEXT_TOTAL_SLOW     = 256;
    localparam int NEXT_TOTAL_FAST     = 128;
    localparam int SAR_STEP_CYCLES     = 4;
    localparam int RESULT_BITS         = 10;

    localparam logic [8:0] DELAY_SLOW_CYCLES =
        9'(DELAY_MIN_SLOW * CYCLES_PER_STATE);
    localparam logic [8:0] DELAY_FAST_CYCLES =
        9'(DELAY_MIN_FAST * CYCLES_PER_STATE);
    localparam logic [3:0] PHASE_SLOW_LAST   = 4'hb;
    localparam logic [8:0] SAMPLE_SLOW_CYCLES =
        9'(SAMPLE_SLOW_STATES * CYCLES_PER_STATE);
    localparam logic [8:0] SAMPLE_FAST_CYCLES =
        9'(SAMPLE_FAST_STATES * CYCLES_PER_STATE);
    localparam logic [8:0] CONV_FIRST_SLOW_CYCLES = 9'((TOTAL_MIN_SLOW
        - DELAY_MIN_SLOW - SAMPLE_SLOW_STATES) * CYCLES_PER_STATE);
    localparam logic [8:0] CONV_FIRST_FAST_CYCLES = 9'((TOTAL_MIN_FAST
        - DELAY_MIN_FAST - SAMPLE_FAST_STATES) * CYCLES_PER_STATE);
    localparam logic [8:0] CONV_NEXT_SLOW_CYCLES = 9'((NEXT_TOTAL_SLOW
        - SAMPLE_SLOW_STATES) * CYCLES_PER_STATE);
    localparam logic [8:0] CONV_NEXT_FAST_CYCLES = 9'((NEXT_TOTAL_FAST
        - SAMPLE_FAST_STATES) * CYCLES_PER_STATE);
    localparam logic [8:0] SAR_WINDOW_CYCLES =
        9'(RESULT_BITS * SAR_STEP_CYCLES);

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_DELAY   = 2'b01,
        ST_SAMPLE  = 2'b10,
        ST_CONVERT = 2'b11
    } seq_state_type;

endpackage

// file: src/bit_sync.sv
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes each bit changes slowly enough to be sampled as a level.
`timescale 1ns/100ps
`default_nettype none
module bit_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;  // Metastable stage, read only by stage2
        logic [WIDTH-1:0] stage2;  // Settled copy
    } sync_state_type;

    sync_state_type r;       // Registered state
    sync_state_type next_r;  // Next state

    // Shift the input through both stages
    always_comb begin
        next_r        = r;
        next_r.stage1 = async_in;
        next_r.stage2 = r.stage1;
    end

    // Register the state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign sync_out = r.stage2;

endmodule // bit_sync
`default_nettype wire

// file: src/sar_adc_sequencer.sv
// Control sequencer for an eight-input 10-bit SAR converter with an
// Avalon-MM slave for its registers.
// Assumes an analog front end: a mux, a sample-and-hold, a DAC and a
// comparator whose output is asynchronous to clk.
//
// Summary of operation
// - 16-bit results, low byte via 8-bit latch
// - High-byte read returns byte, latches low byte
// - 10-bit SAR; single, multi, scan modes
// - Single: start stays set, self-clears at end
// - Single end stores result, sets done flag
// - Done flag cleared by read-then-write-zero
// - Multi/scan always start at group's first input
// - Next channel starts right after previous ends
// - Each channel result stored when it completes
// - Multi end: set flag, clear start, stop
// - Scan cycles while start set; restart from first
// - Scan pass end sets flag, keeps converting
// - Start delay, then sample, then convert
// - Delay 17-28/129 sample or 10-17/65
// - First conversion totals 514-525 or 259-266
// - Later conversions fixed 256 or 128 states
// - Enabled trigger falling edge sets start
// - Interrupt request only while enable set
// - Group bit and two select bits choose channels
// - Multi bit and scan bit select mode
// - Reset and standby restore register defaults
`timescale 1ns/100ps
`default_nettype none
module sar_adc_sequencer (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        standby,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        ext_trigger_n,
    input  wire logic        cmp_in,
    output logic      [2:0]  analog_channel,
    output logic             sample_hold,
    output logic      [9:0]  dac_code,
    output logic             conv_done_irq
);
    import sar_adc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State of the whole block
    typedef struct packed {
        seq_state_type   state;           // Sequencer phase
        logic [8:0]      count;           // Cycles left in the phase
        logic [1:0]      chan;            // Channel within the group
        logic            first;           // First conversion since start
        logic [9:0]      code;            // Successive-approximation code
        logic [3:0][9:0] result;          // Results A to D
        logic [7:0]      low_byte_latch;  // Holding latch for low bytes
        logic            conv_done_flag;  // End of conversion
        logic            done_irq_enable; // Request enable
        logic            conv_start;      // Conversion running
        logic            multi;           // Multi or scan selected
        logic            conv_time_select;// Fast timing
        logic            channel_group_bit;
        logic [1:0]      channel_sel;     // Select hi and lo bits
        logic            trigger_enable_hi;
        logic            trigger_enable_lo;
        logic            scan_select;     // Scan instead of multi
        logic            flag_read_armed; // Flag seen set by a read
        logic            wait_done;       // Wait state already given
        logic [31:0]     readdata;        // Registered read data
        logic            trig_prev;       // Trigger level last cycle
        logic [3:0]      phase;           // Free phase for start delay
    } core_state_type;

    core_state_type r;       // Registered state
    core_state_type next_r;  // Next state

    logic [1:0] sync_level;  // Synchronised comparator and trigger
    logic       cmp_s;       // Comparator: input above DAC level
    logic       trig_s;      // Synchronised trigger pin

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; both pins are outside the clock domain
    bit_sync #(
        .WIDTH    (2)
    ) u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in ({cmp_in, ext_trigger_n}),
        .sync_out (sync_level)
    );

    assign cmp_s  = sync_level[1];
    assign trig_s = sync_level[0];

    ////////////////////////////////////////////////////////////////////////
    // Helpers for the next-state process
    logic       bus_req;      // A request is on the bus
    logic       bus_accept;   // Request completes at this edge
    logic       lane0;        // Low byte lane written
    logic [7:0] status_byte;  // Current ctrl_status_reg image
    logic [7:0] ctrl_byte;    // Current ctrl_reg image
    logic [7:0] rd_byte;      // Selected read byte
    logic [1:0] rd_index;     // Result register addressed
    logic [8:0] delay_len;    // Start delay for this start
    logic [8:0] sample_len;   // Sample time
    logic [8:0] conv_len;     // Convert phase length
    logic [3:0] bit_index;    // SAR bit under trial
    logic       set_done;     // Hardware sets the done flag
    logic       trig_fall;    // Falling edge on the trigger

    assign bus_req    = avs_read | avs_write;
    assign bus_accept = bus_req & r.wait_done;
    assign lane0      = avs_byteenable[0];
    assign rd_index   = avs_address[4:3];
    assign trig_fall  = r.trig_prev & ~trig_s;
    assign bit_index  = r.count[5:2];

    assign status_byte = {r.conv_done_flag, r.done_irq_enable,
                          r.conv_start, r.multi, r.conv_time_select,
                          r.channel_group_bit, r.channel_sel};
    // Reserved bits 4:3 read as zero, 2:0 as one
    assign ctrl_byte = {r.trigger_enable_hi, r.trigger_enable_lo,
                        r.scan_select, 2'b00, CTRL_LOW_ONES};

    // Delay depends on where the free phase stands at the start
    assign delay_len = r.conv_time_select
        ? DELAY_FAST_CYCLES + {6'h00, r.phase[2:0]}
        : DELAY_SLOW_CYCLES + {5'h00, r.phase};
    assign sample_len = r.conv_time_select ? SAMPLE_FAST_CYCLES
                                           : SAMPLE_SLOW_CYCLES;
    // First conversion carries the remainder of the documented total
    assign conv_len = r.first
        ? (r.conv_time_select ? CONV_FIRST_FAST_CYCLES
                              : CONV_FIRST_SLOW_CYCLES)
        : (r.conv_time_select ? CONV_NEXT_FAST_CYCLES
                              : CONV_NEXT_SLOW_CYCLES);

    ////////////////////////////////////////////////////////////////////////
    // Read multiplexer; unmapped addresses read as zero
    always_comb begin
        rd_byte = 8'h00;
        if (avs_address == OFS_CTRL_STATUS) begin
            rd_byte = status_byte;
        end else if (avs_address == OFS_CTRL) begin
            rd_byte = ctrl_byte;
        end else if (avs_address[5] == 1'b0 && avs_address[1:0] == 2'b00)
        begin
            if (avs_address[2] == 1'b0) begin
                rd_byte = r.result[rd_index][9:2];
            end else begin
                rd_byte = r.low_byte_latch;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state: sequencer, then trigger, then bus, then flag set
    always_comb begin
        next_r   = r;
        set_done = 1'b0;

        // Free-running phase; only its value at the start matters
        if (r.phase == PHASE_SLOW_LAST) begin
            next_r.phase = 4'h0;
        end else begin
            next_r.phase = r.phase + 4'h1;
        end

        // Sequencer, one count per clock state
        unique case (r.state)
            ST_IDLE: begin
                if (r.conv_start) begin
                    next_r.state = ST_DELAY;
                    next_r.first = 1'b1;
                    next_r.count = delay_len - 9'h001;
                    // Multi and scan begin at the group's first input
                    next_r.chan  = r.multi ? 2'b00 : r.channel_sel;
                end
            end
            ST_DELAY: begin
                if (r.count == 9'h000) begin
                    next_r.state = ST_SAMPLE;
                    next_r.count = sample_len - 9'h001;
                end else begin
                    next_r.count = r.count - 9'h001;
                end
            end
            ST_SAMPLE: begin
                if (r.count == 9'h000) begin
                    next_r.state = ST_CONVERT;
                    next_r.count = conv_len - 9'h001;
                    next_r.code  = 10'h000;
                end else begin
                    next_r.count = r.count - 9'h001;
                end
            end
            ST_CONVERT: begin
                // One bit every four cycles over the last forty
                if (r.count < SAR_WINDOW_CYCLES) begin
                    if (r.count[1:0] == 2'b11) begin
                        next_r.code[bit_index] = 1'b1;
                    end else if (r.count[1:0] == 2'b00 && !cmp_s) begin
                        next_r.code[bit_index] = 1'b0;
                    end
                end
                if (r.count == 9'h000) begin
                    next_r.result[r.chan] = next_r.code;
                    next_r.first = 1'b0;
                    next_r.count = sample_len - 9'h001;
                    if (!r.multi) begin
                        // Single mode finishes and goes idle
                        next_r.state      = ST_IDLE;
                        next_r.conv_start = 1'b0;
                        set_done          = 1'b1;
                    end else if (r.chan == r.channel_sel) begin
                        set_done = 1'b1;
                        if (r.scan_select) begin
                            // Scan wraps to the first input at once
                            next_r.chan  = 2'b00;
                            next_r.state = ST_SAMPLE;
                        end else begin
                            next_r.state      = ST_IDLE;
                            next_r.conv_start = 1'b0;
                        end
                    end else begin
                        // Next channel in ascending order
                        next_r.chan  = r.chan + 2'b01;
                        next_r.state = ST_SAMPLE;
                    end
                end else begin
                    next_r.count = r.count - 9'h001;
                end
            end
        endcase

        // External trigger acts exactly like a software start
        next_r.trig_prev = trig_s;
        if (trig_fall && r.trigger_enable_hi && r.trigger_enable_lo) begin
            next_r.conv_start = 1'b1;
        end

        // Bus: one wait state, then the access completes
        if (bus_req && !r.wait_done) begin
            next_r.wait_done = 1'b1;
            next_r.readdata  = avs_read ? {24'h000000, rd_byte} : 32'h0;
        end else begin
            next_r.wait_done = 1'b0;
        end

        if (bus_accept && avs_read) begin
            if (avs_address[5] == 1'b0 && avs_address[2:0] == 3'b000) begin
                // High byte read captures the low byte for later
                next_r.low_byte_latch =
                    {r.result[rd_index][1:0], 6'h00};
            end
            if (avs_address == OFS_CTRL_STATUS
                && r.readdata[BIT_DONE_FLAG]) begin
                next_r.flag_read_armed = 1'b1;
            end
        end

        if (bus_accept && avs_write && lane0) begin
            if (avs_address == OFS_CTRL_STATUS) begin
                next_r.done_irq_enable   = avs_writedata[BIT_IRQ_ENABLE];
                next_r.multi             = avs_writedata[BIT_MULTI];
                next_r.conv_time_select  = avs_writedata[BIT_TIME_SELECT];
                next_r.channel_group_bit = avs_writedata[BIT_GROUP];
                next_r.channel_sel       = avs_writedata[1:0];
                if (!avs_writedata[BIT_CONV_START]) begin
                    // Abort: the channel in flight stores its result only if it completes in this same cycle
                    next_r.conv_start = 1'b0;
                    next_r.state      = ST_IDLE;
                end else begin
                    next_r.conv_start = 1'b1;
                end
                // Writing one to the flag has no effect
                if (!avs_writedata[BIT_DONE_FLAG] && r.flag_read_armed)
                begin
                    next_r.conv_done_flag = 1'b0;
                end
                next_r.flag_read_armed = 1'b0;
            end else if (avs_address == OFS_CTRL) begin
                next_r.trigger_enable_hi = avs_writedata[BIT_TRIG_EN_HI];
                next_r.trigger_enable_lo = avs_writedata[BIT_TRIG_EN_LO];
                next_r.scan_select       = avs_writedata[BIT_SCAN];
            end
        end

        // A completion in the clearing cycle is never lost
        if (set_done) begin
            next_r.conv_done_flag = 1'b1;
        end

        // Standby acts like reset on every register
        if (standby) begin
            next_r = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register the state; all-zero gives the documented defaults
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign avs_waitrequest = bus_req & ~r.wait_done;
    assign avs_readdata    = r.readdata;
    assign analog_channel  = {r.channel_group_bit, r.chan};
    assign sample_hold     = (r.state == ST_SAMPLE);
    assign dac_code        = r.code;
    // Level request follows flag and enable directly
    assign conv_done_irq   = r.conv_done_flag & r.done_irq_enable;

endmodule // sar_adc_sequencer
`default_nettype wire

// file: testbench/sar_adc_front.sv
// Ideal analog front end: one fixed level per input, exact comparator.
// Assumes the mux select and trial code come straight from the sequencer.
`timescale 1ns/100ps
`default_nettype none
module sar_adc_front (
    input  wire logic [2:0] analog_channel,
    input  wire logic [9:0] dac_code,
    input  wire logic [9:0] level [8],
    output logic            cmp_in
);
    // High while the selected input is at or above the trial code
    assign cmp_in = level[analog_channel] >= dac_code;
endmodule // sar_adc_front
`default_nettype wire

// file: testbench/sar_adc_sva.sv
// Port checker for the converter sequencer.
// Assumes it is bound to sar_adc_sequencer and sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module sar_adc_sva (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        standby,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    input wire logic        sample_hold,
    input wire logic [2:0]  analog_channel,
    input wire logic [9:0]  dac_code,
    input wire logic        conv_done_irq
);
    logic       sh_q;  // Sample phase one cycle ago
    logic       armed; // A sample start seen, no write since
    logic [9:0] hold;  // Cycles spent in the current sample phase
    logic [9:0] gap;   // Cycles since the last sample start, saturating
    wire        req = avs_read | avs_write;
    wire        rise = sample_hold & ~sh_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////
    // Helper counters; a write may abort, so it disarms the gap check
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {sh_q, armed, hold, gap} <= '0;
        end else begin
            sh_q  <= sample_hold;
            hold  <= sample_hold ? hold + 10'h001 : 10'h000;
            gap   <= rise ? 10'h001 : gap + {9'h000, ~&gap};
            armed <= (avs_write | standby) ? 1'b0 : armed | rise;
        end
    end
    sequence s_one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    AST_WAIT_ONE: assert property (req && !$past(req) |-> s_one_wait)
        else $error("wait state count wrong");
    AST_WAIT_IDLE: assert property (!req |-> !avs_waitrequest)
        else $error("wait without request");
    AST_RD_BYTE: assert property (avs_read && !avs_waitrequest
        |-> avs_readdata[31:8] == 24'h000000)
        else $error("read data wider than a byte");
    AST_SAMPLE_LEN: assert property (!sample_hold && sh_q
        && !$past(avs_write) && !$past(standby)
        |-> hold == 10'd129 || hold == 10'd65)
        else $error("sample phase length wrong");
    AST_GAP: assert property (rise && armed
        |-> gap inside {10'd128, 10'd249, 10'd256, 10'd497})
        else $error("conversion period wrong");
    AST_CHAN_HOLD: assert property (sample_hold && sh_q
        |-> $stable(analog_channel))
        else $error("channel moved while sampling");
    AST_DAC_HOLD: assert property (sample_hold && sh_q
        |-> $stable(dac_code))
        else $error("trial code moved while sampling");
    AST_IRQ_FALL: assert property ($fell(conv_done_irq)
        |-> $past(avs_write) || $past(standby))
        else $error("request dropped on its own");
endmodule // sar_adc_sva
bind sar_adc_sequencer sar_adc_sva chk (
    .clk, .rst, .standby, .avs_read, .avs_write, .avs_waitrequest,
    .avs_readdata, .sample_hold, .analog_channel, .dac_code, .conv_done_irq
);
`default_nettype wire

// file: testbench/sar_adc_sequencer_tb_top.sv
// Self-checking bench for the converter sequencer.
// Assumes the ideal front end model and the bound port checker.
`timescale 1ns/100ps
`default_nettype none
module sar_adc_sequencer_tb_top;
    import sar_adc_pkg::*;
    logic        clk, rst, standby, avs_read, avs_write, ext_trigger_n;
    logic        avs_waitrequest, cmp_in, sample_hold, conv_done_irq;
    logic [5:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0]  avs_byteenable; // Lane 0 gates every register write
    logic [2:0]  analog_channel;
    logic [9:0]  dac_code;
    logic [9:0]  level [8]; // Input levels, all distinct
    int          error_cnt, num_checks, i, cyc = 0;
    initial level = '{10'h1e3, 10'h2b7, 10'h155, 10'h3ff,
                      10'h0c3, 10'h241, 10'h19a, 10'h3c8};
    sar_adc_sequencer uut (.clk, .rst, .standby, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .ext_trigger_n, .cmp_in, .analog_channel,
        .sample_hold, .dac_code, .conv_done_irq);
    sar_adc_front front (.analog_channel, .dac_code, .level, .cmp_in);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Hang guard, far above the under two thousand cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, got);
        num_checks = num_checks + 1;
        if (got !== e) begin
            error_cnt = error_cnt + 1;
            $display("BAD %s expected %h seen %h", n, e, got);
        end
    endtask
    // One bus access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        avs_read      <= ~wr;
        avs_write     <= wr;
        avs_address   <= a;
        avs_writedata <= {24'h0, d};
        // Look mid-cycle, where waitrequest and read data have settled;
        // looking in the edge's own time step races the design's flops
        do @(negedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        // The access completes at this edge, then the request drops
        @(posedge clk);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e, string n);
        bus(1'b0, a, 8'h00);
        chk(n, {24'h0, e}, q);
    endtask
    // Polls status; the read that sees the flag also arms its clearing
    task automatic wait_done();
        for (int k = 0; k < 600; k++) begin
            bus(1'b0, OFS_CTRL_STATUS, 8'h00);
            if (q[BIT_DONE_FLAG] === 1'b1) break;
        end
    endtask
    // High byte first, then the latched low byte
    task automatic res(input int ch);
        logic [5:0] a;
        a = 6'(8 * (ch % 4));
        rd(a, level[ch][9:2], "result high");
        rd(a + 6'h04, {level[ch][1:0], 6'h00}, "result low");
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        {rst, standby, avs_read, avs_write, ext_trigger_n} = 5'h11;
        {avs_address, avs_writedata, error_cnt, num_checks} = '0;
        avs_byteenable = 4'hf;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_CTRL_STATUS, CTRL_STATUS_RESET, "status");
        rd(OFS_CTRL, CTRL_RESET, "ctrl");
        rd(6'h28, 8'h00, "unmapped");
        bus(1'b1, OFS_RESULT_A_HI, 8'hff);
        rd(OFS_RESULT_A_HI, 8'h00, "result a");
        // Single conversion of input 1, slow timing, request enabled
        bus(1'b1, OFS_CTRL_STATUS, 8'h61);
        rd(OFS_CTRL_STATUS, 8'h61, "status running");
        wait_done();
        chk("status", 32'hc1, q);
        chk("irq", 32'h1, {31'h0, conv_done_irq});
        bus(1'b1, OFS_CTRL_STATUS, 8'h41);
        rd(OFS_CTRL_STATUS, 8'h41, "status");
        chk("irq", 32'h0, {31'h0, conv_done_irq});
        res(1);
        // Three inputs of the upper group, fast timing, request off
        bus(1'b1, OFS_CTRL_STATUS, 8'h3e);
        wait_done();
        chk("status", 32'h9e, q);
        chk("irq", 32'h0, {31'h0, conv_done_irq});
        for (i = 4; i < 7; i++) res(i);
        rd(OFS_RESULT_D_HI, 8'h00, "result d");
        // Scan of input 0 started by the trigger pin, two passes
        bus(1'b1, OFS_CTRL, 8'hff);
        rd(OFS_CTRL, 8'he7, "ctrl");
        bus(1'b1, OFS_CTRL_STATUS, 8'h18);
        rd(OFS_CTRL_STATUS, 8'h18, "status");
        @(posedge clk) ext_trigger_n <= 1'b0;
        wait_done();
        chk("status", 32'hb8, q);
        bus(1'b1, OFS_CTRL_STATUS, 8'h38);
        wait_done();
        chk("status", 32'hb8, q);
        bus(1'b1, OFS_CTRL_STATUS, 8'h18);
        rd(OFS_CTRL_STATUS, 8'h18, "status");
        res(0);
        // A write without lane 0 must leave the register alone
        @(posedge clk) avs_byteenable <= 4'he;
        bus(1'b1, OFS_CTRL, 8'h00);
        @(posedge clk) avs_byteenable <= 4'hf;
        rd(OFS_CTRL, 8'he7, "ctrl masked");
        // Standby clears everything
        @(posedge clk) standby <= 1'b1;
        @(posedge clk) standby <= 1'b0;
        rd(OFS_CTRL, CTRL_RESET, "ctrl");
        rd(OFS_RESULT_A_HI, 8'h00, "result a");
        end_of_test();
    end
endmodule // sar_adc_sequencer_tb_top
`default_nettype wire
